// ===== src/sensor_host.sv
// two-wire host end: measurement requests and data fetches
`timescale 1ns/1ns
module sensor_host #(
   parameter sensor_link_pkg::core_clk_t CORE_CLK =
      sensor_link_pkg::CORE_4MHZ,
   parameter int RATE_HZ = sensor_link_pkg::RATE_FAST_HZ,
   parameter int WORD_W = sensor_link_pkg::WORD_W
) (
   input wire logic clk,
   input wire logic nrst,
   sensor_link_if.host link,
   input wire logic cmd_valid,
   input wire logic cmd_read,
   input wire logic cmd_recover,
   output logic cmd_ready,
   output logic rsp_valid,
   output logic [WORD_W-1:0] rsp_data,
   output logic rsp_nack
);
   import sensor_link_pkg::*;

   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_START = 3'b001,
      H_BIT = 3'b010,
      H_STOP = 3'b011,
      H_BUF = 3'b100
   } host_state_t;

   // a 1 MHz core never gets more than the slow rate
   localparam int QTR = (CORE_CLK == CORE_1MHZ || RATE_HZ <= RATE_SLOW_HZ)
      ? QTR_SLOW_CYC : QTR_FAST_CYC;
   localparam logic [7:0] QTR_LAST = 8'(QTR - 1);
   localparam logic [5:0] BUF_LAST = 6'(BUF_CYC - 1);
   localparam logic [3:0] NBYTES = 4'(WORD_W / 8);

   host_state_t st_q, st_d;
   logic [1:0] ph_q, ph_d;
   logic [7:0] qc_q, qc_d, sh_q, sh_d;
   logic [5:0] bf_q, bf_d;
   logic [3:0] bit_q, bit_d, byte_q, byte_d;
   logic [WORD_W-1:0] rx_q, rx_d, dat_q, dat_d;
   logic rd_q, rd_d, rec_q, rec_d, nack_q, nack_d, nko_q, nko_d;
   logic scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d;
   logic rdy_q, rdy_d, rv_q, rv_d, tick;

   // quarter-bit enable drives every SCL and SDA move
   always_comb begin
      st_d = st_q;
      ph_d = ph_q;
      sh_d = sh_q;
      bf_d = bf_q;
      bit_d = bit_q;
      byte_d = byte_q;
      rx_d = rx_q;
      dat_d = dat_q;
      rd_d = rd_q;
      rec_d = rec_q;
      nack_d = nack_q;
      nko_d = nko_q;
      scl_oe_d = scl_oe_q;
      sda_oe_d = sda_oe_q;
      rv_d = 1'b0;
      tick = qc_q == QTR_LAST;
      qc_d = tick ? 8'h00 : qc_q + 8'h01;
      if (tick) begin
         ph_d = ph_q + 2'h1;
      end
      case (st_q)
         H_IDLE: begin
            qc_d = 8'h00;
            ph_d = 2'h0;
            if (cmd_valid && rdy_q) begin
               rd_d = cmd_read;
               rec_d = cmd_recover;
               nack_d = 1'b0;
               bit_d = 4'h0;
               byte_d = 4'h0;
               sh_d = {TARGET_ADDR, cmd_read ? RW_READ : RW_WRITE};
               st_d = H_START;
            end
         end
         H_START: begin
            if (tick && ph_q == 2'h1) begin
               sda_oe_d = 1'b1;
            end else if (tick && ph_q == 2'h3) begin
               scl_oe_d = 1'b1;
               st_d = H_BIT;
            end
         end
         H_BIT: begin
            if (tick) begin
               case (ph_q)
                  2'h0: begin
                     // SDA moves only while SCL is low
                     if (bit_q != BIT_ACK) begin
                        sda_oe_d = (byte_q == 4'h0 && !rec_q) ?
                           !sh_q[7] : 1'b0;
                     end else begin
                        sda_oe_d = byte_q != 4'h0 && byte_q != NBYTES;
                     end
                  end
                  2'h1: scl_oe_d = 1'b0;
                  2'h2: begin
                     if (bit_q != BIT_ACK) begin
                        sh_d = {sh_q[6:0], 1'b0};
                        if (byte_q != 4'h0) begin
                           rx_d = {rx_q[WORD_W-2:0], link.sda};
                        end
                     end else if (byte_q == 4'h0) begin
                        nack_d = link.sda;
                     end
                  end
                  default: begin
                     scl_oe_d = 1'b1;
                     if (rec_q) begin
                        st_d = H_STOP;
                     end else if (bit_q != BIT_ACK) begin
                        bit_d = bit_q + 4'h1;
                     end else begin
                        bit_d = 4'h0;
                        byte_d = byte_q + 4'h1;
                        if (byte_q == NBYTES || (byte_q == 4'h0 &&
                              (nack_q || !rd_q))) begin
                           st_d = H_STOP;
                        end
                     end
                  end
               endcase
            end
         end
         H_STOP: begin
            if (tick) begin
               case (ph_q)
                  2'h0: sda_oe_d = 1'b1;
                  2'h1: scl_oe_d = 1'b0;
                  2'h2: sda_oe_d = 1'b0;
                  default: begin
                     bf_d = 6'h00;
                     st_d = H_BUF;
                  end
               endcase
            end
         end
         H_BUF: begin
            // bus free time before any new start
            bf_d = bf_q + 6'h01;
            if (bf_q == BUF_LAST) begin
               qc_d = 8'h00;
               ph_d = 2'h0;
               if (rec_q) begin
                  // the lone recovery clock shifted the address byte once
                  rec_d = 1'b0;
                  sh_d = {TARGET_ADDR, rd_q ? RW_READ : RW_WRITE};
                  bit_d = 4'h0;
                  st_d = H_START;
               end else begin
                  rv_d = 1'b1;
                  dat_d = rx_q;
                  nko_d = nack_q;
                  st_d = H_IDLE;
               end
            end
         end
         default: st_d = H_IDLE;
      endcase
      rdy_d = st_d == H_IDLE && !(cmd_valid && rdy_q);
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_q <= H_IDLE;
         ph_q <= 2'h0;
         qc_q <= 8'h00;
         sh_q <= 8'h00;
         bf_q <= 6'h00;
         bit_q <= 4'h0;
         byte_q <= 4'h0;
         rx_q <= '0;
         dat_q <= '0;
         rd_q <= 1'b0;
         rec_q <= 1'b0;
         nack_q <= 1'b0;
         nko_q <= 1'b0;
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
         rdy_q <= 1'b0;
         rv_q <= 1'b0;
      end else begin
         st_q <= st_d;
         ph_q <= ph_d;
         qc_q <= qc_d;
         sh_q <= sh_d;
         bf_q <= bf_d;
         bit_q <= bit_d;
         byte_q <= byte_d;
         rx_q <= rx_d;
         dat_q <= dat_d;
         rd_q <= rd_d;
         rec_q <= rec_d;
         nack_q <= nack_d;
         nko_q <= nko_d;
         scl_oe_q <= scl_oe_d;
         sda_oe_q <= sda_oe_d;
         rdy_q <= rdy_d;
         rv_q <= rv_d;
      end
   end

   assign link.scl_o = 1'b0;
   assign link.scl_oe = scl_oe_q;
   assign link.sda_h_o = 1'b0;
   assign link.sda_h_oe = sda_oe_q;
   assign cmd_ready = rdy_q;
   assign rsp_valid = rv_q;
   assign rsp_data = dat_q;
   assign rsp_nack = nko_q;
endmodule

// ===== src/sensor_link_if.sv
// open-drain two-wire link joining host and target
`timescale 1ns/1ns
interface sensor_link_if;
   logic scl_o;
   logic scl_oe;
   logic sda_h_o;
   logic sda_h_oe;
   logic sda_t_o;
   logic sda_t_oe;
   logic scl;
   logic sda;
   // wired-and with pull-up: a line is low only while someone drives low
   assign scl = !(scl_oe && !scl_o);
   assign sda = !(sda_h_oe && !sda_h_o) && !(sda_t_oe && !sda_t_o);
   modport host (output scl_o, scl_oe, sda_h_o, sda_h_oe, input scl, sda);
   modport target (output sda_t_o, sda_t_oe, input scl, sda);
endinterface

// ===== src/sensor_link_pkg.sv
// constants and types shared by both ends of the two-wire sensor link
// Overview of operation
// - target answers only bus address 0x28
// - update-rate conversion or sleep mode on request
// - update mode works on either output, sleep mode only on I2C; SPI default
// - commands: measurement request and data fetch
// - 4 MHz core: 400/100 kHz; 1 MHz: 100 kHz
// - bare start-stop makes next transaction fail
// - host sends extra start to recover
// - repeated start also fails next transaction
// - host never drops SDA before first rise, except on the recovery clock
// - first address bit zero holds SDA low
// - configuration fixed with calibration data
// - no interface path alters configuration
package sensor_link_pkg;
   localparam int CLK_HZ = 25_000_000;
   localparam logic [6:0] TARGET_ADDR = 7'h28;
   localparam int RATE_FAST_HZ = 400_000;
   localparam int RATE_SLOW_HZ = 100_000;
   localparam int CORE_FAST_HZ = 4_000_000;
   localparam int CORE_SLOW_HZ = 1_000_000;
   localparam int CORE_FAST_CYC = CLK_HZ / CORE_FAST_HZ;
   localparam int CORE_SLOW_CYC = CLK_HZ / CORE_SLOW_HZ;
   // least SCL high width and bus free time, in ns
   localparam int T_HIGH_NS = 600;
   localparam int T_BUF_NS = 2000;
   localparam int HIGH_FAST_CYC = (T_HIGH_NS * (CLK_HZ / 1_000_000) + 999)
      / 1000;
   localparam int HIGH_SLOW_CYC = HIGH_FAST_CYC
      * (CORE_FAST_HZ / CORE_SLOW_HZ);
   localparam int BUF_CYC = (T_BUF_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int QTR_FAST_CYC = (CLK_HZ + 4 * RATE_FAST_HZ - 1)
      / (4 * RATE_FAST_HZ);
   localparam int QTR_SLOW_CYC = (CLK_HZ + 4 * RATE_SLOW_HZ - 1)
      / (4 * RATE_SLOW_HZ);
   localparam int WORD_W = 32;
   localparam int FIFO_DEPTH = 8;
   localparam int UPD_TICKS = 1000;
   localparam logic [3:0] BIT_ACK = 4'h8;
   localparam logic RW_READ = 1'b1;
   localparam logic RW_WRITE = 1'b0;
   typedef enum logic {MODE_UPDATE = 1'b0, MODE_SLEEP = 1'b1} op_mode_t;
   typedef enum logic {OUT_SPI = 1'b0, OUT_I2C = 1'b1} out_sel_t;
   typedef enum logic {CORE_4MHZ = 1'b0, CORE_1MHZ = 1'b1} core_clk_t;
endpackage

// ===== src/sensor_target.sv
// measurement fifo and two-wire target end of the sensor link
`timescale 1ns/1ns
module sample_fifo #(
   parameter int W = 32,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [W-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [W-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [AW:0] cnt_q, cnt_d;
   logic rdy_q, rdy_d, val_q, val_d;
   logic push, pop;

   // flags kept in flops so both ready and valid are registered
   always_comb begin
      push = in_valid && rdy_q;
      pop = out_ready && val_q;
      wp_d = push ? AW'(wp_q + 1'b1) : wp_q;
      rp_d = pop ? AW'(rp_q + 1'b1) : rp_q;
      cnt_d = cnt_q;
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
      rdy_d = cnt_d != (AW+1)'(DEPTH);
      val_d = cnt_d != '0;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
         rdy_q <= 1'b0;
         val_q <= 1'b0;
      end else begin
         wp_q <= wp_d;
         rp_q <= rp_d;
         cnt_q <= cnt_d;
         rdy_q <= rdy_d;
         val_q <= val_d;
      end
   end

   // storage has no reset; contents only read while counted valid
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_q] <= in_data;
      end
   end

   assign in_ready = rdy_q;
   assign out_valid = val_q;
   assign out_data = mem[rp_q];
endmodule

module sensor_target #(
   parameter sensor_link_pkg::op_mode_t OP_MODE = sensor_link_pkg::MODE_SLEEP,
   parameter sensor_link_pkg::out_sel_t OUT_SEL = sensor_link_pkg::OUT_SPI,
   parameter sensor_link_pkg::core_clk_t CORE_CLK =
      sensor_link_pkg::CORE_4MHZ,
   parameter int WORD_W = sensor_link_pkg::WORD_W,
   parameter int FIFO_DEPTH = sensor_link_pkg::FIFO_DEPTH,
   parameter int UPD_TICKS = sensor_link_pkg::UPD_TICKS
) (
   input wire logic clk,
   input wire logic nrst,
   sensor_link_if.target link,
   input wire logic [WORD_W-1:0] meas_data,
   input wire logic meas_valid,
   output logic meas_ready,
   output logic conv_req,
   output logic poisoned,
   output logic busy
);
   import sensor_link_pkg::*;

   typedef enum logic [2:0] {
      D_IDLE = 3'b000,
      D_ADDR = 3'b001,
      D_AACK = 3'b010,
      D_TX = 3'b011,
      D_TACK = 3'b100,
      D_RX = 3'b101,
      D_RACK = 3'b110,
      D_IGN = 3'b111
   } tgt_state_t;

   localparam int NBYTES = WORD_W / 8;
   localparam logic [6:0] HIGH_MIN = 7'((CORE_CLK == CORE_1MHZ) ?
      HIGH_SLOW_CYC : HIGH_FAST_CYC);
   localparam logic [4:0] CORE_LAST = 5'(((CORE_CLK == CORE_1MHZ) ?
      CORE_SLOW_CYC : CORE_FAST_CYC) - 1);
   localparam logic [15:0] UPD_LAST = 16'(UPD_TICKS - 1);
   localparam logic [3:0] BYTE_LAST = 4'(NBYTES - 1);

   tgt_state_t state_q, state_d;
   logic scl_q, sda_q;
   logic [7:0] sr_q, sr_d, tx_q, tx_d, nb;
   logic [3:0] bit_q, bit_d, byte_q, byte_d;
   logic [WORD_W-1:0] word_q, word_d, last_q, last_d;
   logic rw_q, rw_d, hack_q, hack_d, seen_q, seen_d;
   logic poison_q, poison_d, oe_q, oe_d, conv_q, conv_d, busy_q, busy_d;
   logic [6:0] hi_q, hi_d;
   logic [4:0] div_q, div_d;
   logic [15:0] upd_q, upd_d;
   logic scl_rise, scl_fall, start_ev, stop_ev, active, link_on;
   logic pop, conv_mr, tick;
   logic [WORD_W-1:0] f_data;
   logic f_valid;

   sample_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .nrst(nrst),
      .in_data(meas_data),
      .in_valid(meas_valid),
      .in_ready(meas_ready),
      .out_data(f_data),
      .out_valid(f_valid),
      .out_ready(pop)
   );

   // bus events from the previous sample of both lines
   assign scl_rise = link.scl && !scl_q;
   assign scl_fall = !link.scl && scl_q;
   assign start_ev = link.scl && scl_q && sda_q && !link.sda;
   assign stop_ev = link.scl && scl_q && !sda_q && link.sda;
   assign active = state_q != D_IDLE && state_q != D_IGN;
   assign link_on = OUT_SEL == OUT_I2C;

   // target sequencer: sample on SCL rise, drive on SCL fall
   always_comb begin
      state_d = state_q;
      sr_d = sr_q;
      tx_d = tx_q;
      bit_d = bit_q;
      byte_d = byte_q;
      word_d = word_q;
      last_d = last_q;
      rw_d = rw_q;
      hack_d = hack_q;
      poison_d = poison_q;
      oe_d = oe_q;
      pop = 1'b0;
      conv_mr = 1'b0;
      nb = word_q[WORD_W-9 -: 8];
      seen_d = seen_q || scl_rise;
      hi_d = !link.scl ? 7'h00 : (hi_q == 7'h7F ? hi_q : hi_q + 7'h01);
      if (!link_on) begin
         // factory set to the other output: stay off the wire
         state_d = D_IDLE;
         oe_d = 1'b0;
      end else if (start_ev) begin
         seen_d = 1'b0;
         oe_d = 1'b0;
         bit_d = 4'h0;
         if (poison_q) begin
            poison_d = 1'b0;
            state_d = D_IGN;
         end else if (active) begin
            poison_d = 1'b1;
            state_d = D_IGN;
         end else begin
            state_d = D_ADDR;
         end
      end else if (stop_ev) begin
         if (state_q == D_ADDR && !seen_q) begin
            poison_d = 1'b1;
         end
         state_d = D_IDLE;
         oe_d = 1'b0;
      end else if (scl_fall && active && hi_q < HIGH_MIN) begin
         // clock faster than the core clock allows: drop out
         state_d = D_IGN;
         oe_d = 1'b0;
      end else begin
         case (state_q)
            D_ADDR: begin
               if (scl_rise) begin
                  sr_d = {sr_q[6:0], link.sda};
                  bit_d = bit_q + 4'h1;
               end else if (scl_fall && bit_q == BIT_ACK) begin
                  if (sr_q[7:1] == TARGET_ADDR) begin
                     oe_d = 1'b1;
                     rw_d = sr_q[0];
                     state_d = D_AACK;
                  end else begin
                     state_d = D_IGN;
                  end
               end
            end
            D_AACK: begin
               if (scl_fall) begin
                  oe_d = 1'b0;
                  bit_d = 4'h0;
                  if (rw_q == RW_READ) begin
                     // data fetch: empty fifo repeats the last word
                     pop = f_valid;
                     word_d = f_valid ? f_data : last_q;
                     last_d = word_d;
                     byte_d = 4'h0;
                     oe_d = !word_d[WORD_W-1];
                     tx_d = {word_d[WORD_W-2 -: 7], 1'b0};
                     bit_d = 4'h1;
                     state_d = D_TX;
                  end else begin
                     conv_mr = 1'b1;
                     state_d = D_RX;
                  end
               end
            end
            D_TX: begin
               if (scl_fall && bit_q == BIT_ACK) begin
                  oe_d = 1'b0;
                  state_d = D_TACK;
               end else if (scl_fall) begin
                  oe_d = !tx_q[7];
                  tx_d = {tx_q[6:0], 1'b0};
                  bit_d = bit_q + 4'h1;
               end
            end
            D_TACK: begin
               if (scl_rise) begin
                  hack_d = link.sda;
               end else if (scl_fall) begin
                  if (!hack_q && byte_q != BYTE_LAST) begin
                     byte_d = byte_q + 4'h1;
                     word_d = word_q << 8;
                     oe_d = !nb[7];
                     tx_d = {nb[6:0], 1'b0};
                     bit_d = 4'h1;
                     state_d = D_TX;
                  end else begin
                     state_d = D_IGN;
                  end
               end
            end
            D_RX: begin
               // written bytes are acked and dropped: nothing is stored
               if (scl_rise) begin
                  bit_d = bit_q + 4'h1;
               end else if (scl_fall && bit_q == BIT_ACK) begin
                  oe_d = 1'b1;
                  state_d = D_RACK;
               end
            end
            D_RACK: begin
               if (scl_fall) begin
                  oe_d = 1'b0;
                  bit_d = 4'h0;
                  state_d = D_RX;
               end
            end
            default: begin
            end
         endcase
      end
      busy_d = state_d != D_IDLE && state_d != D_IGN;
   end

   // conversion pacing from the core clock enable
   always_comb begin
      tick = div_q == CORE_LAST;
      div_d = tick ? 5'h00 : div_q + 5'h01;
      upd_d = upd_q;
      if (tick) begin
         upd_d = (upd_q == UPD_LAST) ? 16'h0000 : upd_q + 16'h0001;
      end
      if (OP_MODE == MODE_SLEEP) begin
         conv_d = conv_mr;
      end else begin
         conv_d = tick && upd_q == UPD_LAST;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= D_IDLE;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         sr_q <= 8'h00;
         tx_q <= 8'h00;
         bit_q <= 4'h0;
         byte_q <= 4'h0;
         word_q <= '0;
         last_q <= '0;
         rw_q <= 1'b0;
         hack_q <= 1'b1;
         seen_q <= 1'b0;
         poison_q <= 1'b0;
         oe_q <= 1'b0;
         hi_q <= 7'h00;
         div_q <= 5'h00;
         upd_q <= 16'h0000;
         conv_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         state_q <= state_d;
         scl_q <= link.scl;
         sda_q <= link.sda;
         sr_q <= sr_d;
         tx_q <= tx_d;
         bit_q <= bit_d;
         byte_q <= byte_d;
         word_q <= word_d;
         last_q <= last_d;
         rw_q <= rw_d;
         hack_q <= hack_d;
         seen_q <= seen_d;
         poison_q <= poison_d;
         oe_q <= oe_d;
         hi_q <= hi_d;
         div_q <= div_d;
         upd_q <= upd_d;
         conv_q <= conv_d;
         busy_q <= busy_d;
      end
   end

   // open drain: only ever pulls low
   assign link.sda_t_o = 1'b0;
   assign link.sda_t_oe = oe_q;
   assign conv_req = conv_q;
   assign poisoned = poison_q;
   assign busy = busy_q;
endmodule

// ===== test/sensor_link_assertions.sv
// protocol checks on the open-drain link between host and target
`timescale 1ns/1ns
module sensor_link_checker (
   input wire logic clk,
   input wire logic nrst,
   input wire logic scl_oe,
   input wire logic sda_h_oe,
   input wire logic sda_t_oe,
   input wire logic scl,
   input wire logic sda
);
   logic scl_q, scl_d, sda_q, sda_d, start_w, stop_w;
   logic [3:0] rise_q, rise_d;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // line history; rise count saturates so long reads cannot wrap to 8
   always_comb begin
      scl_d = scl;
      sda_d = sda;
      start_w = scl && scl_q && sda_q && !sda;
      stop_w = scl && scl_q && !sda_q && sda;
      rise_d = rise_q;
      if (start_w || stop_w) begin
         rise_d = 4'h0;
      end else if (scl && !scl_q && rise_q != 4'hF) begin
         rise_d = rise_q + 4'h1;
      end
   end
   // register only
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         rise_q <= 4'h0;
      end else begin
         scl_q <= scl_d;
         sda_q <= sda_d;
         rise_q <= rise_d;
      end
   end
   start_low_a: assert property (start_w |=> !sda [*8])
      else $error("sda left low level right after start");
   start_hold_a: assert property (start_w |=> !sda until !scl)
      else $error("sda moved before first scl low");
   start_clock_a: assert property (start_w |-> ##[1:300] !scl)
      else $error("start not followed by a clock");
   scl_high_min_a: assert property (
      $rose(scl) |-> scl [*8] ##1 scl [*7])
      else $error("scl high phase too short");
   target_data_a: assert property ($changed(sda_t_oe) |-> !scl)
      else $error("target moved sda while scl high");
   addr_ack_a: assert property (
      $fell(scl) && rise_q == 4'h8 |-> ##[1:3] sda_t_oe)
      else $error("address not acknowledged");
   ack_slot_a: assert property (
      scl && !scl_q && rise_q == 4'h8 |-> sda_t_oe && !sda_h_oe)
      else $error("ack slot not held by target alone");
   no_restart_a: assert property (start_w |-> rise_q == 4'h0)
      else $error("start inside a transfer");
   cover property (start_w);
   cover property (stop_w && rise_q > 4'h8);
   cover property ($rose(sda_t_oe) && rise_q > 4'h9);
endmodule

// ===== test/tb_pressure_sensor_i2c_target.sv
// bench joining host and target ends, plus a hand-driven spare link
`timescale 1ns/1ns
module tb_pressure_sensor_i2c_target;
   import sensor_link_pkg::*;
   localparam logic [WORD_W-1:0] BASE = 32'hA50F_0000;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [WORD_W-1:0] meas_data = '0;
   logic meas_valid = 1'b0;
   logic cmd_valid = 1'b0;
   logic cmd_read = 1'b0;
   logic cmd_recover = 1'b0;
   logic meas_ready, conv_req, poisoned, busy, p2, c2;
   logic cmd_ready, rsp_valid, rsp_nack, nak;
   logic [WORD_W-1:0] rsp_data, got;
   int err_total = 0;
   int tests_run = 0;
   int conv_cnt = 0;
   int c2_cnt = 0;
   int n0;
   sensor_link_if link();
   sensor_link_if bad();
   sensor_host sensor_host_i (.clk(clk), .nrst(nrst), .link(link.host),
      .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_recover(cmd_recover),
      .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .rsp_nack(rsp_nack));
   sensor_target #(.OUT_SEL(OUT_I2C), .UPD_TICKS(4)) sensor_target_i (
      .clk(clk), .nrst(nrst), .link(link.target), .meas_data(meas_data),
      .meas_valid(meas_valid), .meas_ready(meas_ready), .conv_req(conv_req),
      .poisoned(poisoned), .busy(busy));
   // spare target sees bench-made line faults and free-runs update mode
   sensor_target #(.OP_MODE(MODE_UPDATE), .OUT_SEL(OUT_I2C), .UPD_TICKS(4))
      spare_sensor_target_i (.clk(clk), .nrst(nrst), .link(bad.target),
      .meas_data('0), .meas_valid(1'b0), .meas_ready(), .conv_req(c2),
      .poisoned(p2), .busy());
   sensor_link_checker sensor_link_checker_i (.clk(clk), .nrst(nrst),
      .scl_oe(link.scl_oe), .sda_h_oe(link.sda_h_oe),
      .sda_t_oe(link.sda_t_oe), .scl(link.scl), .sda(link.sda));
   // clock and conversion pulse count
   initial forever #20 clk = ~clk;
   always @(posedge clk) if (conv_req === 1'b1) conv_cnt <= conv_cnt + 1;
   always @(posedge clk) if (c2 === 1'b1) c2_cnt <= c2_cnt + 1;
   task automatic chk(input logic [WORD_W-1:0] g, input logic [WORD_W-1:0] e);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // one host command, held until taken, answer captured when it pulses
   task automatic run_cmd(input logic rd, input logic rec);
      @(posedge clk);
      cmd_read <= rd;
      cmd_recover <= rec;
      cmd_valid <= 1'b1;
      repeat (100) begin
         @(posedge clk);
         if (cmd_ready === 1'b1) break;
      end
      cmd_valid <= 1'b0;
      repeat (6000) begin
         @(posedge clk);
         if (rsp_valid === 1'b1) break;
      end
      if (rsp_valid !== 1'b1) begin
         err_total++;
         $display("[ERR] %0t no response from host", $time);
      end
      got = rsp_data;
      nak = rsp_nack;
   endtask
   // pairs of {scl low, sda low} on the spare link, long enough for free time
   task automatic wire_seq(input logic [15:0] seq, input int n);
      @(posedge clk);
      for (int i = n - 1; i >= 0; i--) begin
         bad.scl_oe <= seq[2*i+1];
         bad.sda_h_oe <= seq[2*i];
         repeat (60) @(posedge clk);
      end
   endtask
   // watchdog sized well beyond ten fetches of about 3000 cycles each
   initial begin
      repeat (80000) @(posedge clk);
      err_total++;
      summarize();
   end
   initial begin
      bad.scl_o = 1'b0;
      bad.sda_h_o = 1'b0;
      bad.scl_oe = 1'b0;
      bad.sda_h_oe = 1'b0;
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      repeat (2) @(posedge clk);
      meas_valid <= 1'b1;
      for (int i = 0; i < FIFO_DEPTH; i++) begin
         meas_data <= BASE + WORD_W'(i);
         do @(posedge clk); while (meas_ready !== 1'b1);
      end
      meas_valid <= 1'b0;
      @(posedge clk);
      #1 chk(WORD_W'(meas_ready), 32'h0);
      for (int i = 0; i < FIFO_DEPTH; i++) begin
         run_cmd(1'b1, 1'b0);
         chk(got, BASE + WORD_W'(i));
         chk(WORD_W'(nak), 32'h0);
      end
      run_cmd(1'b1, 1'b0);
      chk(got, BASE + 32'h7);
      chk(WORD_W'(nak), 32'h0);
      $display("fetch test done");
      n0 = conv_cnt;
      run_cmd(1'b0, 1'b0);
      chk(WORD_W'(conv_cnt - n0), 32'h1);
      chk(WORD_W'(nak), 32'h0);
      // fresh word so a stale host buffer cannot pass the recovery fetch
      meas_data <= BASE + 32'h8;
      meas_valid <= 1'b1;
      @(posedge clk);
      meas_valid <= 1'b0;
      run_cmd(1'b1, 1'b1);
      chk(got, BASE + 32'h8);
      chk(WORD_W'(nak), 32'h0);
      chk(WORD_W'({busy, poisoned}), 32'h0);
      $display("request and recovery test done");
      wire_seq(16'h0004, 2);
      chk(WORD_W'(p2), 32'h1);
      wire_seq(16'h78B4, 8);
      chk(WORD_W'(p2), 32'h0);
      wire_seq(16'h0784, 6);
      chk(WORD_W'(p2), 32'h1);
      wire_seq(16'h78B4, 8);
      chk(WORD_W'(p2), 32'h0);
      $display("line fault test done");
      n0 = c2_cnt;
      repeat (240) @(posedge clk);
      chk(WORD_W'(c2_cnt - n0), WORD_W'(240 / (4 * CORE_FAST_CYC)));
      $display("update rate test done");
      summarize();
   end
endmodule
